// ==== core/async_rx_address_detect.sv ====
// Asynchronous serial receiver with 9-bit address detection and Wishbone registers
//
// Behaviour
// - Address detection only while addr_detect_en set
// - Address mode keeps only ninth-bit-one characters
// - Buffer load sets rx_flag; interrupt if enabled
// - Data read returns oldest character low byte
// - Clearing cont_rx_en clears overrun error
// - Filtered characters report ninth bit one
// - Status bit 0 shows top ninth bit
// - Receive control layout and zero reset
// - Transmit control layout and reset value
// - Data and divisor registers reset to zero
// - Half-bit start recheck, then full-bit sampling
// - Two-character buffer, third completion overruns
// - After overrun keep buffered, accept nothing
// - Per-character framing error, shown for top
`timescale 1ns/1ps
`include "async_rx_consts.svh"

module async_rx_address_detect
	import async_rx_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        resetn,
	// Classic Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [5:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Serial line and baud generator
	input  wire logic        rxPin,
	input  wire logic        sampleTick,
	// Status outputs and baud generator settings
	output logic             rxFlag,
	output logic             rxIrq,
	output logic [7:0]       baudDivisor,
	output logic             baudHighSel
);

	//////////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic [1:0]  sync;
		rx_state_t   state;
		logic [3:0]  tickCnt;
		logic [3:0]  bitCnt;
		logic [8:0]  shift;
		rx_entry_t   entry0;
		rx_entry_t   entry1;
		logic [1:0]  count;
		logic        rdPtr;
		logic [7:0]  rxCtrl;
		logic        overrun;
		logic [7:0]  baudDiv;
		logic [7:0]  txCtrl;
		logic        irqEn;
		logic [31:0] rdData;
		logic        ack;
	} state_t;

	state_t s_q;
	state_t s_d;

	logic      busReq;
	logic      wrLo;
	logic      rdData;
	logic      portEn;
	logic      contEn;
	logic      nineSel;
	logic      addrMode;
	logic      charDone;
	logic      keepChar;
	logic      stopBit;
	logic      pushOk;
	rx_entry_t topEntry;
	logic [3:0] lastBit;

	assign busReq   = wb_cyc_i && wb_stb_i && !s_q.ack;
	assign wrLo     = busReq && wb_we_i && wb_sel_i[0];
	assign rdData   = busReq && !wb_we_i && (wb_adr_i == `OFF_RX_DATA);
	assign portEn   = s_q.rxCtrl[`RXC_PORT_EN];
	assign contEn   = s_q.rxCtrl[`RXC_CONT_EN];
	assign nineSel  = s_q.rxCtrl[`RXC_NINE_SEL];
	assign addrMode = nineSel && s_q.rxCtrl[`RXC_ADDR_DET];
	assign lastBit  = nineSel ? 4'h9 : 4'h8;
	assign stopBit  = s_q.sync[1];
	assign charDone = (s_q.state == RX_STOP) && sampleTick && (s_q.tickCnt == `TICKS_FULL_BIT);
	// Non-address characters vanish without flag or overrun
	assign keepChar = !addrMode || s_q.shift[8];
	assign pushOk   = charDone && keepChar && contEn && !s_q.overrun;
	assign topEntry = s_q.rdPtr ? s_q.entry1 : s_q.entry0;

	//////////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		s_d      = s_q;
		s_d.sync = {s_q.sync[0], rxPin};
		s_d.ack  = busReq;

		// Receive state machine, paced by the 16x tick
		if (!portEn)
		begin
			s_d.state = RX_IDLE;
		end
		else if (sampleTick)
		begin
			s_d.tickCnt = s_q.tickCnt + 4'h1;
			unique case (s_q.state)
				RX_IDLE:
				begin
					s_d.tickCnt = 4'h0;
					if (!s_q.sync[1] && contEn)
					begin
						s_d.state = RX_START;
					end
				end
				RX_START:
				begin
					if (s_q.tickCnt == `TICKS_HALF_BIT)
					begin
						s_d.tickCnt = 4'h0;
						s_d.bitCnt  = 4'h0;
						// A glitch aborts quietly
						s_d.state   = s_q.sync[1] ? RX_IDLE : RX_DATA;
					end
				end
				RX_DATA:
				begin
					if (s_q.tickCnt == `TICKS_FULL_BIT)
					begin
						s_d.bitCnt = s_q.bitCnt + 4'h1;
						// LSB first; an 8-bit character lands right-aligned
						if (nineSel)
						begin
							s_d.shift = {s_q.sync[1], s_q.shift[8:1]};
						end
						else
						begin
							s_d.shift = {1'b0, s_q.sync[1], s_q.shift[7:1]};
						end
						if (s_q.bitCnt + 4'h1 == lastBit)
						begin
							s_d.state = RX_STOP;
						end
					end
				end
				RX_STOP:
				begin
					if (s_q.tickCnt == `TICKS_FULL_BIT)
					begin
						s_d.state = RX_IDLE;
					end
				end
			endcase
		end

		// Two-entry buffer: pop on data read, push on completion
		if (rdData && s_q.count != 2'd0)
		begin
			s_d.rdPtr = !s_q.rdPtr;
			s_d.count = s_q.count - 2'd1;
		end
		if (charDone && keepChar && contEn && s_q.count == 2'd2 && !rdData)
		begin
			s_d.overrun = 1'b1;
		end
		else if (pushOk)
		begin
			if (s_q.rdPtr ^ s_q.count[0])
			begin
				s_d.entry1 = '{data: s_q.shift, frameErr: !stopBit};
			end
			else
			begin
				s_d.entry0 = '{data: s_q.shift, frameErr: !stopBit};
			end
			s_d.count = s_d.count + 2'd1;
		end

		// Register writes
		if (wrLo)
		begin
			unique case (wb_adr_i)
				`OFF_RX_CTRL:
				begin
					s_d.rxCtrl = {wb_dat_i[7:3], 3'b000};
				end
				`OFF_BAUD_DIV:
				begin
					s_d.baudDiv = wb_dat_i[7:0];
				end
				`OFF_TX_CTRL:
				begin
					// Shift-empty and the unused bit are not writable
					s_d.txCtrl = (wb_dat_i[7:0] & `TXC_WR_MASK) | `TX_CTRL_RESET;
				end
				`OFF_IRQ_CTRL:
				begin
					s_d.irqEn = wb_dat_i[0];
				end
				default:
				begin
				end
			endcase
		end
		// Overrun is left set while receive stays enabled; clearing the enable wins
		if (!s_d.rxCtrl[`RXC_CONT_EN])
		begin
			s_d.overrun = 1'b0;
		end
		if (!s_d.rxCtrl[`RXC_PORT_EN])
		begin
			s_d.overrun = 1'b0;
			s_d.count   = 2'd0;
			s_d.rdPtr   = 1'b0;
		end

		// Registered read data
		s_d.rdData = 32'h0000_0000;
		if (busReq && !wb_we_i)
		begin
			unique case (wb_adr_i)
				`OFF_RX_DATA:
				begin
					s_d.rdData[7:0] = (s_q.count != 2'd0) ? topEntry.data[7:0] : 8'h00;
				end
				`OFF_RX_CTRL:
				begin
					s_d.rdData[7:0] = {s_q.rxCtrl[7:3],
						topEntry.frameErr && s_q.count != 2'd0,
						s_q.overrun,
						topEntry.data[8]};
				end
				`OFF_BAUD_DIV:
				begin
					s_d.rdData[7:0] = s_q.baudDiv;
				end
				`OFF_TX_CTRL:
				begin
					s_d.rdData[7:0] = s_q.txCtrl;
				end
				`OFF_IRQ_CTRL:
				begin
					s_d.rdData[1:0] = {rxFlag, s_q.irqEn};
				end
				default:
				begin
				end
			endcase
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			s_q         <= '0;
			s_q.sync    <= 2'b11;
			s_q.rxCtrl  <= `RX_CTRL_RESET;
			s_q.baudDiv <= `BAUD_DIV_RESET;
			s_q.txCtrl  <= `TX_CTRL_RESET;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign wb_dat_o    = s_q.rdData;
	assign wb_ack_o    = s_q.ack;
	assign rxFlag      = portEn && contEn && (s_q.count != 2'd0);
	assign rxIrq       = rxFlag && s_q.irqEn;
	assign baudDivisor = s_q.baudDiv;
	assign baudHighSel = s_q.txCtrl[2];

	//////////////////////////////////////////////////////////////////////////////
	// Bus and receive path checks
	a_filter_drop: assert property (@(posedge clk_sys) disable iff (!resetn)
		charDone && addrMode && !s_q.shift[8] |=> s_q.count == $past(s_q.count) || $past(rdData))
		else $error("address filter let a data character in");
	a_addr_ninth: assert property (@(posedge clk_sys) disable iff (!resetn)
		pushOk && addrMode && s_q.count == 2'd0 && s_d.rxCtrl[`RXC_PORT_EN] |=> topEntry.data[8])
		else $error("filtered character without ninth bit");
	a_push_flag: assert property (@(posedge clk_sys) disable iff (!resetn)
		pushOk && portEn && s_d.rxCtrl[`RXC_CONT_EN] && s_d.rxCtrl[`RXC_PORT_EN] |=> rxFlag)
		else $error("flag not set after buffer load");
	a_third_over: assert property (@(posedge clk_sys) disable iff (!resetn)
		charDone && keepChar && contEn && s_q.count == 2'd2 && !rdData && s_d.rxCtrl[`RXC_CONT_EN]
		|=> s_q.overrun)
		else $error("third character did not overrun");
	a_over_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
		s_q.overrun && !rdData |=> s_q.count <= $past(s_q.count))
		else $error("character accepted during overrun");
	a_over_clear: assert property (@(posedge clk_sys) disable iff (!resetn)
		!contEn |-> !s_q.overrun)
		else $error("overrun stays with receive disabled");
	a_start_abort: assert property (@(posedge clk_sys) disable iff (!resetn)
		s_q.state == RX_START && sampleTick && s_q.tickCnt == `TICKS_HALF_BIT && s_q.sync[1] && portEn
		|=> s_q.state == RX_IDLE && !s_q.overrun == !$past(s_q.overrun))
		else $error("false start not aborted");
	a_bit_count: assert property (@(posedge clk_sys) disable iff (!resetn)
		s_q.state == RX_DATA |-> s_q.bitCnt < lastBit)
		else $error("bit counter past character length");
	a_bus_ack: assert property (@(posedge clk_sys) disable iff (!resetn)
		busReq |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not a one-cycle pulse");
	a_entry_store: assert property (@(posedge clk_sys) disable iff (!resetn)
		pushOk && s_q.count == 2'd0 && s_d.rxCtrl[`RXC_PORT_EN]
		|=> topEntry.data == $past(s_q.shift) && topEntry.frameErr == !$past(stopBit))
		else $error("buffered character or framing flag wrong");
	a_push_count: assert property (@(posedge clk_sys) disable iff (!resetn)
		pushOk && !rdData && s_q.count != 2'd2 && s_d.rxCtrl[`RXC_PORT_EN]
		|=> s_q.count == $past(s_q.count) + 2'd1)
		else $error("completed character not counted");
	a_rx_pop: assert property (@(posedge clk_sys) disable iff (!resetn)
		rdData && s_q.count != 2'd0 && !charDone && s_d.rxCtrl[`RXC_PORT_EN]
		|=> s_q.count == $past(s_q.count) - 2'd1)
		else $error("data read did not release a character");
	a_start_go: assert property (@(posedge clk_sys) disable iff (!resetn)
		s_q.state == RX_START && sampleTick && s_q.tickCnt == `TICKS_HALF_BIT && !s_q.sync[1] && portEn
		|=> s_q.state == RX_DATA && s_q.bitCnt == 4'h0 && s_q.tickCnt == 4'h0)
		else $error("valid start bit not taken");
	a_nine_clear: assert property (@(posedge clk_sys) disable iff (!resetn)
		s_q.state == RX_STOP && !nineSel |-> !s_q.shift[8])
		else $error("eight-bit character carries a ninth bit");

	// Main scenarios: address push, overrun, framing, false start, full buffer
	c_addr_push: cover property (@(posedge clk_sys) disable iff (!resetn) pushOk && addrMode);
	c_overrun: cover property (@(posedge clk_sys) disable iff (!resetn) $rose(s_q.overrun));
	c_frame_err: cover property (@(posedge clk_sys) disable iff (!resetn) pushOk && !stopBit);
	c_false_start: cover property (@(posedge clk_sys) disable iff (!resetn)
		s_q.state == RX_START && sampleTick && s_q.tickCnt == `TICKS_HALF_BIT && s_q.sync[1]);
	c_buffer_full: cover property (@(posedge clk_sys) disable iff (!resetn) s_q.count == 2'd2);

endmodule : async_rx_address_detect

// ==== core/async_rx_consts.svh ====
// Register offsets, field positions, reset values and timing counts of the serial receiver
`ifndef ASYNC_RX_CONSTS_SVH
`define ASYNC_RX_CONSTS_SVH
`define OFF_RX_DATA     6'h00
`define OFF_RX_CTRL     6'h04
`define OFF_BAUD_DIV    6'h08
`define OFF_TX_CTRL     6'h0C
`define OFF_IRQ_CTRL    6'h10
`define RXC_PORT_EN     7
`define RXC_NINE_SEL    6
`define RXC_SINGLE_EN   5
`define RXC_CONT_EN     4
`define RXC_ADDR_DET    3
`define RXC_FRAME_ERR   2
`define RXC_OVERRUN     1
`define RXC_NINTH_BIT   0
`define TXC_WR_MASK     8'hF5
`define TX_CTRL_RESET   8'h02
`define RX_CTRL_RESET   8'h00
`define BAUD_DIV_RESET  8'h00
`define TICKS_HALF_BIT  4'h7
`define TICKS_FULL_BIT  4'hF
`endif

// ==== core/async_rx_pkg.sv ====
// Types shared by the serial receiver
package async_rx_pkg;
	typedef enum logic [1:0] {
		RX_IDLE  = 2'b00,
		RX_START = 2'b01,
		RX_DATA  = 2'b10,
		RX_STOP  = 2'b11
	} rx_state_t;

	typedef struct packed {
		logic [8:0] data;
		logic       frameErr;
	} rx_entry_t;
endpackage : async_rx_pkg

// ==== tb/serial_tx_model.sv ====
// Remote serial transmitter model driving the receive line
`timescale 1ns/1ps
module serial_tx_model
(
	// Clock and sample tick
	input  wire logic clk_sys,
	input  wire logic sampleTick,
	// Serial line, idles high between frames
	output logic      rxPin
);
	initial rxPin = 1'b1;
	////////////////////////////////
	task automatic bitOut(input logic v, input int ticks);
		rxPin <= v;
		repeat (ticks) @(posedge clk_sys iff sampleTick);
	endtask : bitOut
	// LSB first, then a stop bit at the level asked for
	task automatic send(input logic [8:0] d, input logic nine, input logic stopV);
		bitOut(1'b0, 16);
		for (int i = 0; i < (nine ? 9 : 8); i++)
			bitOut(d[i], 16);
		bitOut(stopV, 16);
		bitOut(1'b1, 16);
	endtask : send
	// Low for less than half a bit, so the start recheck sees high
	task automatic glitch();
		bitOut(1'b0, 3);
		bitOut(1'b1, 32);
	endtask : glitch
endmodule : serial_tx_model

// ==== tb/tb_top.sv ====
// Self-checking bench for the serial receiver with address detection
`timescale 1ns/1ps
`include "async_rx_consts.svh"
module tb_top;
	logic        clk_sys;
	logic        resetn;
	logic        cyc;
	logic        stb;
	logic        we;
	logic        sampleTick = 1'b0;
	logic        rxPin;
	logic        wb_ack_o;
	logic        rxFlag;
	logic        rxIrq;
	logic        baudHighSel;
	logic        ovr;
	logic        irqEn;
	logic [3:0]  sel;
	logic [5:0]  adr;
	logic [7:0]  ctl;
	logic [7:0]  baudDivisor;
	logic [9:0]  q[$];
	logic [31:0] wdat;
	logic [31:0] rdat;
	logic [31:0] wb_dat_o;
	logic [5:0]  offs[5] = '{`OFF_RX_DATA, `OFF_RX_CTRL, `OFF_BAUD_DIV, `OFF_TX_CTRL, 6'h14};
	logic [7:0]  rstv[5] = '{8'h00, 8'h00, 8'h00, 8'h02, 8'h00};
	int          errors;
	int          compares;
	int          seed;
	////////////////////////////////
	async_rx_address_detect i_async_rx_address_detect (.clk_sys(clk_sys), .resetn(resetn),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rxPin(rxPin),
		.sampleTick(sampleTick), .rxFlag(rxFlag), .rxIrq(rxIrq),
		.baudDivisor(baudDivisor), .baudHighSel(baudHighSel));
	serial_tx_model i_serial_tx_model (.clk_sys(clk_sys), .sampleTick(sampleTick), .rxPin(rxPin));
	initial
	begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) sampleTick <= ~sampleTick;
	////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			errors++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		// Only the watchdog ends a wait for the answer
		do
		begin
			@(posedge clk_sys);
		end
		while (wb_ack_o !== 1'b1);
		rdat = wb_dat_o;
		chk("ack", wb_ack_o, 1);
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_sys);
	endtask : wb
	task automatic setCtl(input logic [7:0] c);
		wb(1, `OFF_RX_CTRL, {24'h0, c});
		ctl = c;
	endtask : setCtl
	// Receive enable goes last; clearing it also drops any overrun
	task automatic cfg(input logic [7:0] c);
		wb(1, `OFF_BAUD_DIV, 32'h19);
		wb(1, `OFF_IRQ_CTRL, {31'h0, irqEn});
		setCtl(8'h80);
		setCtl(c & 8'hEF);
		setCtl(c);
		ovr = 1'b0;
	endtask : cfg
	task automatic rx(input logic [8:0] d, input logic stopV);
		logic nine;
		nine = ctl[`RXC_NINE_SEL];
		if (!nine)
			d[8] = 1'b0;
		i_serial_tx_model.send(d, nine, stopV);
		if (!(ovr || (nine && ctl[`RXC_ADDR_DET] && !d[8])))
		begin
			if (q.size() == 2)
				ovr = 1'b1;
			else
				q.push_back({~stopV, d});
		end
		repeat (4) @(posedge clk_sys);
		chk("flag", rxFlag, q.size() != 0);
		chk("irq", rxIrq, q.size() != 0 && irqEn);
	endtask : rx
	// Status is read before data, as software must
	task automatic pop();
		logic [9:0] e;
		e = q.pop_front();
		wb(0, `OFF_RX_CTRL, 0);
		chk("status", rdat, {ctl[7:3], e[9], ovr, e[8]});
		wb(0, `OFF_RX_DATA, 0);
		chk("data", rdat, e[7:0]);
	endtask : pop
	task automatic stop_test();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : stop_test
	////////////////////////////////
	initial
	begin
		#200000;
		errors++;
		stop_test();
	end
	initial
	begin
		{cyc, stb, we, resetn, ovr} = 5'h00;
		adr = 6'h00;
		wdat = 32'h0000_0000;
		ctl = 8'h00;
		sel = 4'hF;
		errors = 0;
		compares = 0;
		seed = 32'h8e0f3b4a;
		repeat (8) @(posedge clk_sys);
		resetn <= 1'b1;
		@(posedge clk_sys);
		foreach (offs[i])
		begin
			wb(0, offs[i], 0);
			chk("reset", rdat, rstv[i]);
		end
		wb(1, `OFF_TX_CTRL, 32'hFF);
		wb(0, `OFF_TX_CTRL, 0);
		chk("txctrl", rdat, 32'hF7);
		chk("baud_high_sel", baudHighSel, 1);
		// A write without the low byte lane selected is acknowledged but ignored
		sel <= 4'hE;
		wb(1, `OFF_BAUD_DIV, 32'hA5);
		sel <= 4'hF;
		wb(0, `OFF_BAUD_DIV, 0);
		chk("selmask", rdat, 0);
		$display("test registers done");
		irqEn = 1'b1;
		cfg(8'h90);
		chk("div", baudDivisor, 32'h19);
		wb(0, `OFF_IRQ_CTRL, 0);
		chk("irqctl", rdat, 1);
		repeat (2) rx(9'($random(seed)), 1'b1);
		repeat (2) pop();
		wb(0, `OFF_RX_DATA, 0);
		chk("empty", rdat, 0);
		rx(9'($random(seed)), 1'b0);
		pop();
		i_serial_tx_model.glitch();
		chk("glitch", rxFlag, 0);
		$display("test eight bit done");
		repeat (3) rx(9'($random(seed)), 1'b1);
		pop();
		rx(9'($random(seed)), 1'b1);
		pop();
		cfg(8'h90);
		rx(9'($random(seed)), 1'b1);
		pop();
		$display("test overrun done");
		irqEn = 1'b0;
		cfg(8'hD8);
		rx({1'b0, 8'($random(seed))}, 1'b1);
		rx({1'b1, 8'($random(seed))}, 1'b1);
		pop();
		setCtl(8'hD0);
		rx({1'b0, 8'($random(seed))}, 1'b1);
		pop();
		setCtl(8'hD8);
		rx({1'b0, 8'($random(seed))}, 1'b1);
		cfg(8'h98);
		rx(9'($random(seed)), 1'b1);
		pop();
		$display("test address detect done");
		stop_test();
	end
endmodule : tb_top
